// file: hdl/ppt_pkg.sv
package ppt_pkg;

   // Core clock rate and period
   localparam int CLK_MHZ       = 40;
   localparam int CLK_PERIOD_NS = 25;

   // Register offsets on the management port
   localparam logic [15:0] INTERLEAVE_CONFIG_OFS           = 16'h0489;
   localparam logic [15:0] SLEEP_REQUEST_TIMER_CONTROL_OFS = 16'h0493;
   localparam logic [15:0] JABBER_TIMEOUT_CONFIG_OFS       = 16'h0496;
   localparam logic [15:0] COMPLIANCE_SYMBOL_CONTROL_OFS   = 16'h0497;
   localparam logic [15:0] WAKE_ON_LAN_CONFIG_OFS          = 16'h04a0;

   // Values after reset
   localparam logic [15:0] INTERLEAVE_RST = 16'h0001;
   localparam logic [15:0] SLEEP_RST      = 16'h0014;
   localparam logic [15:0] JABBER_RST     = 16'h044c;
   localparam logic [15:0] COMPLIANCE_RST = 16'h01c0;
   localparam logic [15:0] WOL_RST        = 16'h1000;
   localparam logic [7:0]  TM1_COUNT_RST  = 8'h3a;

   // Bits that software may change; the rest hold their reset value
   localparam logic [15:0] INTERLEAVE_WMASK = 16'h0007;
   localparam logic [15:0] SLEEP_WMASK      = 16'hffff;
   localparam logic [15:0] JABBER_WMASK     = 16'h07ff;
   localparam logic [15:0] COMPLIANCE_WMASK = 16'h03ff;
   localparam logic [15:0] WOL_WMASK        = 16'hf7ff;

   // Field positions
   localparam int IL_DETECT_BIT    = 0;
   localparam int IL_ENABLE_BIT    = 1;
   localparam int IL_FORCE_BIT     = 2;
   localparam int SLEEP_SEL_LSB    = 4;
   localparam int JABBER_W         = 11;
   localparam int TM1_LSB          = 4;
   localparam int TM1_W            = 6;
   localparam int WOL_MAGIC_BIT    = 0;
   localparam int WOL_PATTERN_BIT  = 1;
   localparam int WOL_SECURE_BIT   = 5;
   localparam int WOL_MASK_BIT     = 6;
   localparam int WOL_ENABLE_BIT   = 7;
   localparam int WOL_LEVEL_BIT    = 8;
   localparam int WOL_PULSE_LSB    = 9;
   localparam int WOL_CLEAR_BIT    = 11;
   localparam int WOL_CRC_GATE_BIT = 12;
   localparam int WOL_SFD_BIT      = 13;
   localparam int WOL_SWAP_LSB     = 14;

   // Sleep-request timer durations
   localparam int SLEEP_T0_US  = 400;
   localparam int SLEEP_T1_US  = 1000;
   localparam int SLEEP_T2_US  = 4000;
   localparam int SLEEP_T3_US  = 8000;
   localparam int SLEEP_T0_CYC = SLEEP_T0_US * CLK_MHZ;
   localparam int SLEEP_T1_CYC = SLEEP_T1_US * CLK_MHZ;
   localparam int SLEEP_T2_CYC = SLEEP_T2_US * CLK_MHZ;
   localparam int SLEEP_T3_CYC = SLEEP_T3_US * CLK_MHZ;
   localparam int SLEEP_CNT_W  = 19;

   // Jabber timeout counts in microsecond ticks
   localparam int JAB_TICK_NS  = 1000;
   localparam int JAB_TICK_CYC = JAB_TICK_NS / CLK_PERIOD_NS;
   localparam int JAB_DIV_W    = 6;

   // Wake pulse width is given in cycles of a 100 MHz reference
   localparam int WAKE_REF_MHZ    = 100;
   localparam int WAKE_PULSE_BASE = 8;
   localparam int WAKE_CNT_W      = 5;

   // Jabber watcher states, Gray coded along idle, watch, trip
   typedef enum logic [1:0] {
      PPT_JAB_IDLE  = 2'b00,
      PPT_JAB_WATCH = 2'b01,
      PPT_JAB_TRIP  = 2'b11
   } ppt_jab_state_t;

   // Decoded configuration handed to the datapath
   typedef struct packed {
      logic                 force_interleave;
      logic                 interleave_en;
      logic                 interleave_detect_en;
      logic [1:0]           sleep_sel;
      logic [JABBER_W-1:0]  jabber_timeout_us;
      logic [TM1_W-1:0]     tm1_field;
      logic [1:0]           nibble_swap;
      logic                 sfd_alt;
      logic                 crc_gate;
      logic [1:0]           pulse_sel;
      logic                 level_mode;
      logic                 wol_en;
      logic                 bit_mask;
      logic                 secure_on;
      logic                 pattern_en;
      logic                 magic_en;
   } ppt_cfg_t;

   // Wake events reported at the end of a received frame
   typedef struct packed {
      logic magic;
      logic pattern;
      logic bad_crc;
   } ppt_wake_evt_t;

   // Sleep timer state
   typedef struct packed {
      logic [SLEEP_CNT_W-1:0] count;
      logic                   done;
   } ppt_timer_state_t;

   // Register bank state
   typedef struct packed {
      logic [15:0]           interleave;
      logic [15:0]           sleep;
      logic [15:0]           jabber;
      logic [15:0]           compliance;
      logic [15:0]           wake_on_lan;
      logic [15:0]           rdata;
      logic                  tx_interleave;
      logic [7:0]            tm1_count;
      ppt_jab_state_t        jstate;
      logic [JAB_DIV_W-1:0]  jdiv;
      logic [JABBER_W-1:0]   jcount;
      logic                  jabber_flag;
      logic                  wake_level;
      logic [WAKE_CNT_W-1:0] pulse_cnt;
      logic                  wake_out;
   } ppt_state_t;

   // Wake pulse length in core cycles, rounded up
   function automatic logic [WAKE_CNT_W-1:0] ppt_pulse_cycles(input logic [1:0] sel);
      int ns;
      ns = (WAKE_PULSE_BASE << sel) * 1000 / WAKE_REF_MHZ;
      return WAKE_CNT_W'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   endfunction

endpackage

// file: hdl/ppt_timer.sv
module ppt_timer
   import ppt_pkg::*;
(
   input  logic                   clock_i,  // Core clock
   input  logic                   srst_i,   // Synchronous reset
   input  logic                   run_i,    // Timer runs while high
   input  logic [SLEEP_CNT_W-1:0] limit_i,  // Cycles to count
   output logic                   done_o    // High once limit reached
);

   ppt_timer_state_t cur;  // Registered state
   ppt_timer_state_t nxt;  // Next state

   // Count while running; dropping run restarts from zero
   always_comb begin
      nxt = cur;
      if (!run_i) begin
         nxt.count = '0;
         nxt.done  = 1'b0;
      end else if (cur.count >= limit_i) begin
         // Hold at the limit so done stays until run drops
         nxt.done = 1'b1;
      end else begin
         nxt.count = cur.count + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cur <= '0;
      end else begin
         cur <= nxt;
      end
   end

   assign done_o = cur.done;

endmodule

// file: hdl/ppt_regs.sv
// The plain strobed port was chosen for this implementation.
module ppt_regs
   import ppt_pkg::*;
#(
   parameter int unsigned SLEEP_T0_CYCLES = SLEEP_T0_CYC,  // Sleep timer, code 00
   parameter int unsigned SLEEP_T1_CYCLES = SLEEP_T1_CYC,  // Sleep timer, code 01
   parameter int unsigned SLEEP_T2_CYCLES = SLEEP_T2_CYC,  // Sleep timer, code 10
   parameter int unsigned SLEEP_T3_CYCLES = SLEEP_T3_CYC   // Sleep timer, code 11
)
(
   input  logic          clock_i,               // Core clock
   input  logic          srst_i,                // Synchronous reset
   input  logic [15:0]   addr_i,                // Register address
   input  logic [15:0]   wdata_i,               // Write data
   input  logic          wr_i,                  // Write strobe
   input  logic          rd_i,                  // Read strobe
   output logic [15:0]   rdata_o,               // Read data, cycle after strobe
   input  logic          rx_interleave_seen_i,  // Receive side found interleave
   output logic          tx_interleave_o,       // Transmit in interleaved form
   output logic          interleave_detect_en_o,// Receive detection allowed
   input  logic          sleep_request_i,       // Sleep request pending
   output logic          sleep_timer_done_o,    // Sleep request timer elapsed
   input  logic          line_active_i,         // Continuous line activity
   output logic          jabber_o,              // Jabber condition
   output logic [7:0]    tm1_symbol_count_o,    // Test Mode 1 symbol count
   input  ppt_wake_evt_t wake_evt_i,            // Frame-end wake events
   output logic          wake_indication_o,     // Wake indication line
   output ppt_cfg_t      cfg_o                  // Decoded configuration
);

   ppt_state_t             cur;         // Registered state
   ppt_state_t             nxt;         // Next state
   ppt_cfg_t               cfg;         // Decoded view of current registers
   logic [SLEEP_CNT_W-1:0] sleep_limit; // Selected sleep duration
   logic                   wake_event;  // Qualified wake event
   logic                   wake_clear;  // Software clear of level indication

   // Address match used by both read and write decode
   function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
      return addr == ofs;
   endfunction

   // Writable bits take new data, fixed bits keep their reset value
   function automatic logic [15:0] merge(input logic [15:0] wd,
                                         input logic [15:0] rst,
                                         input logic [15:0] mask);
      return (wd & mask) | (rst & ~mask);
   endfunction

   // Decode register fields for the rest of the logic
   always_comb begin
      cfg.force_interleave     = cur.interleave[IL_FORCE_BIT];
      cfg.interleave_en        = cur.interleave[IL_ENABLE_BIT];
      cfg.interleave_detect_en = cur.interleave[IL_DETECT_BIT];
      cfg.sleep_sel            = cur.sleep[SLEEP_SEL_LSB +: 2];
      cfg.jabber_timeout_us    = cur.jabber[JABBER_W-1:0];
      cfg.tm1_field            = cur.compliance[TM1_LSB +: TM1_W];
      cfg.nibble_swap          = cur.wake_on_lan[WOL_SWAP_LSB +: 2];
      cfg.sfd_alt              = cur.wake_on_lan[WOL_SFD_BIT];
      cfg.crc_gate             = cur.wake_on_lan[WOL_CRC_GATE_BIT];
      cfg.pulse_sel            = cur.wake_on_lan[WOL_PULSE_LSB +: 2];
      cfg.level_mode           = cur.wake_on_lan[WOL_LEVEL_BIT];
      cfg.wol_en               = cur.wake_on_lan[WOL_ENABLE_BIT];
      cfg.bit_mask             = cur.wake_on_lan[WOL_MASK_BIT];
      cfg.secure_on            = cur.wake_on_lan[WOL_SECURE_BIT];
      cfg.pattern_en           = cur.wake_on_lan[WOL_PATTERN_BIT];
      cfg.magic_en             = cur.wake_on_lan[WOL_MAGIC_BIT];
   end

   // Sleep duration select
   always_comb begin
      case (cfg.sleep_sel)
         2'b00: begin
            sleep_limit = SLEEP_CNT_W'(SLEEP_T0_CYCLES);
         end
         2'b01: begin
            sleep_limit = SLEEP_CNT_W'(SLEEP_T1_CYCLES);
         end
         2'b10: begin
            sleep_limit = SLEEP_CNT_W'(SLEEP_T2_CYCLES);
         end
         default: begin
            sleep_limit = SLEEP_CNT_W'(SLEEP_T3_CYCLES);
         end
      endcase
   end

   // Sleep-request timer; restarts whenever the request drops
   ppt_timer u_sleep_timer (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .run_i   (sleep_request_i),
      .limit_i (sleep_limit),
      .done_o  (sleep_timer_done_o)
   );

   // Wake event qualification; a bad frame is dropped only while gated
   always_comb begin
      wake_event = cfg.wol_en
                 & ((wake_evt_i.magic & cfg.magic_en) | (wake_evt_i.pattern & cfg.pattern_en))
                 & ~(cfg.crc_gate & wake_evt_i.bad_crc);
      wake_clear = wr_i & hit(addr_i, WAKE_ON_LAN_CONFIG_OFS) & wdata_i[WOL_CLEAR_BIT]
                 & cfg.level_mode;
   end

   // Next-state logic for registers, read port, jabber and wake
   always_comb begin
      nxt = cur;

      // Register writes; fixed bits never move
      if (wr_i) begin
         if (hit(addr_i, INTERLEAVE_CONFIG_OFS)) begin
            nxt.interleave = merge(wdata_i, INTERLEAVE_RST, INTERLEAVE_WMASK);
         end
         if (hit(addr_i, SLEEP_REQUEST_TIMER_CONTROL_OFS)) begin
            nxt.sleep = merge(wdata_i, SLEEP_RST, SLEEP_WMASK);
         end
         if (hit(addr_i, JABBER_TIMEOUT_CONFIG_OFS)) begin
            nxt.jabber = merge(wdata_i, JABBER_RST, JABBER_WMASK);
         end
         if (hit(addr_i, COMPLIANCE_SYMBOL_CONTROL_OFS)) begin
            nxt.compliance = merge(wdata_i, COMPLIANCE_RST, COMPLIANCE_WMASK);
         end
         if (hit(addr_i, WAKE_ON_LAN_CONFIG_OFS)) begin
            // Clear bit is self-clearing, so it is never stored
            nxt.wake_on_lan = merge(wdata_i, WOL_RST, WOL_WMASK);
         end
      end

      // Read data stands for one cycle only, zero otherwise
      nxt.rdata = '0;
      if (rd_i) begin
         if (hit(addr_i, INTERLEAVE_CONFIG_OFS)) begin
            nxt.rdata = cur.interleave;
         end else if (hit(addr_i, SLEEP_REQUEST_TIMER_CONTROL_OFS)) begin
            nxt.rdata = cur.sleep;
         end else if (hit(addr_i, JABBER_TIMEOUT_CONFIG_OFS)) begin
            nxt.rdata = cur.jabber;
         end else if (hit(addr_i, COMPLIANCE_SYMBOL_CONTROL_OFS)) begin
            nxt.rdata = cur.compliance;
         end else if (hit(addr_i, WAKE_ON_LAN_CONFIG_OFS)) begin
            nxt.rdata = cur.wake_on_lan;
         end else begin
            // Unmapped address reads as zero
            nxt.rdata = '0;
         end
      end

      // Transmit interleave: forced, or follows the receive side while interleave is enabled
      nxt.tx_interleave = cfg.force_interleave
                        | (cfg.interleave_en & rx_interleave_seen_i);

      // Symbol count is 2*field + 2, at most 128
      nxt.tm1_count = {1'b0, cfg.tm1_field, 1'b0} + 8'h02;

      // Jabber watcher counts microsecond ticks of unbroken activity
      case (cur.jstate)
         PPT_JAB_IDLE: begin
            nxt.jdiv   = '0;
            nxt.jcount = '0;
            if (line_active_i) begin
               nxt.jstate = PPT_JAB_WATCH;
            end
         end
         PPT_JAB_WATCH: begin
            if (!line_active_i) begin
               nxt.jstate = PPT_JAB_IDLE;
            end else if (cur.jdiv == JAB_DIV_W'(JAB_TICK_CYC - 1)) begin
               // One microsecond has passed
               nxt.jdiv = '0;
               if ({1'b0, cur.jcount} + 12'h001 >= {1'b0, cfg.jabber_timeout_us}) begin
                  nxt.jstate = PPT_JAB_TRIP;
               end else begin
                  nxt.jcount = cur.jcount + 1'b1;
               end
            end else begin
               nxt.jdiv = cur.jdiv + 1'b1;
            end
         end
         PPT_JAB_TRIP: begin
            // Held until the activity stops
            if (!line_active_i) begin
               nxt.jstate = PPT_JAB_IDLE;
            end
         end
         default: begin
            nxt.jstate = PPT_JAB_IDLE;
         end
      endcase
      nxt.jabber_flag = (nxt.jstate == PPT_JAB_TRIP);

      // Level mode: event wins over a clear in the same cycle
      if (cfg.level_mode) begin
         nxt.wake_level = (cur.wake_level & ~wake_clear) | wake_event;
         nxt.pulse_cnt  = '0;
      end else begin
         // Pulse mode: a new event restarts the full width
         nxt.wake_level = 1'b0;
         if (wake_event) begin
            nxt.pulse_cnt = ppt_pulse_cycles(cfg.pulse_sel);
         end else if (cur.pulse_cnt != '0) begin
            nxt.pulse_cnt = cur.pulse_cnt - 1'b1;
         end
      end
      nxt.wake_out = cfg.level_mode ? nxt.wake_level : (nxt.pulse_cnt != '0);
   end

   // State register; reset loads documented defaults
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cur            <= '0;
         cur.interleave <= INTERLEAVE_RST;
         cur.sleep      <= SLEEP_RST;
         cur.jabber     <= JABBER_RST;
         cur.compliance <= COMPLIANCE_RST;
         cur.wake_on_lan        <= WOL_RST;
         cur.tm1_count  <= TM1_COUNT_RST;
         cur.jstate     <= PPT_JAB_IDLE;
      end else begin
         cur <= nxt;
      end
   end

   // Outputs, all from flip-flops
   assign rdata_o                = cur.rdata;
   assign tx_interleave_o        = cur.tx_interleave;
   assign interleave_detect_en_o = cur.interleave[IL_DETECT_BIT];
   assign jabber_o               = cur.jabber_flag;
   assign tm1_symbol_count_o     = cur.tm1_count;
   assign wake_indication_o      = cur.wake_out;
   assign cfg_o                  = cfg;

endmodule

// file: verif/ppt_regs_assertions.sv
module ppt_regs_chk
   import ppt_pkg::*;
#(
   parameter int unsigned SLEEP_T0_CYCLES = SLEEP_T0_CYC,  // Code 00
   parameter int unsigned SLEEP_T1_CYCLES = SLEEP_T1_CYC,  // Code 01
   parameter int unsigned SLEEP_T2_CYCLES = SLEEP_T2_CYC,  // Code 10
   parameter int unsigned SLEEP_T3_CYCLES = SLEEP_T3_CYC   // Code 11
)
(
   input logic          clock_i,
   input logic          srst_i,
   input logic [15:0]   addr_i,
   input logic [15:0]   wdata_i,
   input logic          wr_i,
   input logic          rd_i,
   input logic [15:0]   rdata_o,
   input logic          rx_interleave_seen_i,
   input logic          tx_interleave_o,
   input logic          interleave_detect_en_o,
   input logic          sleep_request_i,
   input logic          sleep_timer_done_o,
   input logic          line_active_i,
   input logic          jabber_o,
   input logic [7:0]    tm1_symbol_count_o,
   input ppt_wake_evt_t wake_evt_i,
   input logic          wake_indication_o,
   input ppt_cfg_t      cfg_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);

   logic [18:0] run_cnt_reg;  // Cycles of unbroken sleep request
   logic [16:0] act_cnt_reg;  // Cycles of unbroken line activity
   int          lim;          // Sleep limit for the current code
   int          tj;           // Jabber limit in cycles
   logic        ev;           // Wake event accepted this cycle

   // Run lengths restart in reset so a stale count never meets a fresh edge
   always_ff @(posedge clock_i) begin
      run_cnt_reg <= (sleep_request_i && !srst_i) ? run_cnt_reg + 19'h1 : 19'h0;
      act_cnt_reg <= (line_active_i && !srst_i) ? act_cnt_reg + 17'h1 : 17'h0;
   end

   // Limits from the live setting; a timeout of 0 or 1 trips on the first tick
   always_comb begin
      case (cfg_o.sleep_sel)
         2'b00:   lim = int'(SLEEP_T0_CYCLES);
         2'b01:   lim = int'(SLEEP_T1_CYCLES);
         2'b10:   lim = int'(SLEEP_T2_CYCLES);
         default: lim = int'(SLEEP_T3_CYCLES);
      endcase
      tj = (cfg_o.jabber_timeout_us < 11'd2) ? 40 : 40 * int'(cfg_o.jabber_timeout_us);
   end

   // Qualified wake event, gated by a bad checksum when the gate is on
   assign ev = cfg_o.wol_en & ((wake_evt_i.magic & cfg_o.magic_en) |
               (wake_evt_i.pattern & cfg_o.pattern_en)) &
               !(cfg_o.crc_gate & wake_evt_i.bad_crc);

   // Shortest pulse setting and the quiet span that must end it
   sequence s_pulse_evt;
      ev && !cfg_o.level_mode && cfg_o.pulse_sel == 2'b00;
   endsequence
   sequence s_quiet;
      !ev [*4];
   endsequence

   a_tx_interleave: assert property (
      1 |=> tx_interleave_o == $past(cfg_o.force_interleave |
            (cfg_o.interleave_en & rx_interleave_seen_i)))
      else $error("transmit interleave differs from its controls");
   a_detect_write: assert property (
      wr_i && addr_i == INTERLEAVE_CONFIG_OFS |=> interleave_detect_en_o == $past(wdata_i[0]))
      else $error("detection enable does not follow write");
   a_sleep_span: assert property (
      $rose(sleep_timer_done_o) |-> run_cnt_reg + 1 >= lim && run_cnt_reg <= lim + 4)
      else $error("sleep timer span wrong");
   a_jabber_span: assert property (
      $rose(jabber_o) |-> act_cnt_reg + 1 >= tj && act_cnt_reg <= tj + 4)
      else $error("jabber trip time wrong");
   a_jabber_upper: assert property (
      rd_i && addr_i == JABBER_TIMEOUT_CONFIG_OFS |=> rdata_o[15:11] == 5'h00)
      else $error("jabber upper bits not zero");
   a_symbol_count: assert property (
      1 |=> tm1_symbol_count_o == $past({1'b0, cfg_o.tm1_field, 1'b0}) + 8'h02)
      else $error("symbol count not twice field plus two");
   a_level_clear: assert property (
      wr_i && addr_i == WAKE_ON_LAN_CONFIG_OFS && wdata_i[11] && wdata_i[8] &&
      cfg_o.level_mode && !ev |=> !wake_indication_o)
      else $error("level wake not cleared");
   a_pulse_high: assert property (
      s_pulse_evt |=> wake_indication_o [*4])
      else $error("wake pulse too short");
   a_pulse_end: assert property (
      s_pulse_evt ##1 s_quiet |=> !wake_indication_o)
      else $error("wake pulse too long");
   a_level_hold: assert property (
      cfg_o.level_mode && $past(cfg_o.level_mode) && wake_indication_o && !wr_i
      |=> wake_indication_o)
      else $error("level wake dropped by itself");
   a_crc_gate: assert property (
      cfg_o.crc_gate && wake_evt_i.bad_crc && !wake_indication_o |=> !wake_indication_o)
      else $error("bad checksum raised wake");
endmodule

bind ppt_regs ppt_regs_chk #(
   .SLEEP_T0_CYCLES(SLEEP_T0_CYCLES), .SLEEP_T1_CYCLES(SLEEP_T1_CYCLES),
   .SLEEP_T2_CYCLES(SLEEP_T2_CYCLES), .SLEEP_T3_CYCLES(SLEEP_T3_CYCLES)
) ppt_regs_chk_inst (
   .clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
   .rx_interleave_seen_i, .tx_interleave_o, .interleave_detect_en_o,
   .sleep_request_i, .sleep_timer_done_o, .line_active_i, .jabber_o,
   .tm1_symbol_count_o, .wake_evt_i, .wake_indication_o, .cfg_o
);

// file: verif/test_phy_pcs_tuning_registers.sv
module test_phy_pcs_tuning_registers
   import ppt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LT [4] = '{20, 40, 80, 160};  // Short sleep limits keep the run brief

   logic          clock_i, srst_i, wr_i, rd_i;  // Clock, reset, strobes
   logic [15:0]   addr_i, wdata_i, rdata_o;  // Register port
   logic          rx_interleave_seen_i, tx_interleave_o, interleave_detect_en_o;  // Interleave
   logic          sleep_request_i, sleep_timer_done_o, line_active_i, jabber_o;  // Timers
   logic [7:0]    tm1_symbol_count_o;  // Compliance symbol count
   ppt_wake_evt_t wake_evt_i;  // Frame-end wake events
   logic          wake_indication_o;  // Wake line
   ppt_cfg_t      cfg_o;  // Decoded configuration
   int            n_errors = 0, samples_checked = 0;  // Mismatches, comparisons

   ppt_regs #(.SLEEP_T0_CYCLES(LT[0]), .SLEEP_T1_CYCLES(LT[1]),
              .SLEEP_T2_CYCLES(LT[2]), .SLEEP_T3_CYCLES(LT[3])) ppt_regs_inst (
      .clock_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .rx_interleave_seen_i, .tx_interleave_o, .interleave_detect_en_o,
      .sleep_request_i, .sleep_timer_done_o, .line_active_i, .jabber_o,
      .tm1_symbol_count_o, .wake_evt_i, .wake_indication_o, .cfg_o);

   // Free-running 40 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   task automatic chk(input string what, input logic [15:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Range check for spans whose phase the design picks
   task automatic rng(input string what, input int lo, hi, got);
      samples_checked++;
      if (got < lo || got > hi) begin
         n_errors++;
         $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   // One-cycle write; returns on the edge that takes it
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input string what, input logic [15:0] a, input logic [15:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 chk(what, exp, rdata_o);
   endtask

   task automatic do_reset;
      @(posedge clock_i) srst_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
   endtask

   // Strobe one event, then count wake samples over 80 cycles
   task automatic pulse(input logic [2:0] e, output int n);
      @(posedge clock_i) wake_evt_i <= e;
      @(posedge clock_i) wake_evt_i <= 3'b000;
      n = 0;
      repeat (80) begin
         #1 if (wake_indication_o === 1'b1) n++;
         @(posedge clock_i);
      end
   endtask

   task automatic t_reset;
      rdc("interleave", INTERLEAVE_CONFIG_OFS, 16'h0001);
      rdc("sleep", SLEEP_REQUEST_TIMER_CONTROL_OFS, 16'h0014);
      rdc("jabber", JABBER_TIMEOUT_CONFIG_OFS, 16'd1100);
      rdc("compliance", COMPLIANCE_SYMBOL_CONTROL_OFS, {6'h00, 6'h1c, 4'h0});
      rdc("wake cfg", WAKE_ON_LAN_CONFIG_OFS, 16'h1000);
      chk("symbols", 16'd58, {8'h00, tm1_symbol_count_o});
   endtask

   // All ones everywhere, writes two cycles apart; reserved bits must not move
   task automatic t_readonly;
      logic [15:0] a [5] = '{INTERLEAVE_CONFIG_OFS, SLEEP_REQUEST_TIMER_CONTROL_OFS,
                             JABBER_TIMEOUT_CONFIG_OFS, COMPLIANCE_SYMBOL_CONTROL_OFS,
                             WAKE_ON_LAN_CONFIG_OFS};
      logic [15:0] e [5] = '{16'h0007, 16'hffff, 16'h07ff, 16'h03ff, 16'hf7ff};
      for (int i = 0; i < 5; i++) wr(a[i], 16'hffff);
      for (int i = 0; i < 5; i++) rdc("read back", a[i], e[i]);
      wr(16'h0490, 16'hffff);
      rdc("unmapped", 16'h0490, 16'h0000);
      chk("cfg ones", 16'h1, {15'h0, &cfg_o});
   endtask

   task automatic t_interleave;
      wr(INTERLEAVE_CONFIG_OFS, 16'h0002);
      cyc(2);
      chk("tx unseen", 16'h0, {15'h0, tx_interleave_o});
      @(posedge clock_i) rx_interleave_seen_i <= 1'b1;
      cyc(2);
      chk("tx seen", 16'h1, {15'h0, tx_interleave_o});
      wr(INTERLEAVE_CONFIG_OFS, 16'h0004);
      rx_interleave_seen_i <= 1'b0;
      cyc(2);
      chk("tx forced", 16'h1, {15'h0, tx_interleave_o});
      wr(INTERLEAVE_CONFIG_OFS, 16'h0000);
      cyc(2);
      chk("tx normal", 16'h0, {15'h0, tx_interleave_o});
      chk("detect off", 16'h0, {15'h0, interleave_detect_en_o});
   endtask

   // Every timer code, limit counted from the first sampled request
   task automatic t_sleep;
      int n;
      for (int s = 0; s < 4; s++) begin
         wr(SLEEP_REQUEST_TIMER_CONTROL_OFS, {10'h000, 2'(s), 4'h4});
         @(posedge clock_i) sleep_request_i <= 1'b1;
         n = 0;
         while (sleep_timer_done_o !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            #1 n++;
         end
         rng("sleep span", LT[s], LT[s] + 3, n);
         @(posedge clock_i) sleep_request_i <= 1'b0;
         cyc(2);
         chk("sleep done", 16'h0, {15'h0, sleep_timer_done_o});
      end
   endtask

   task automatic t_jabber;
      int n;
      for (int t = 3; t < 6; t += 2) begin
         wr(JABBER_TIMEOUT_CONFIG_OFS, 16'(t));
         @(posedge clock_i) line_active_i <= 1'b1;
         n = 0;
         while (jabber_o !== 1'b1 && n < 400) begin
            @(posedge clock_i);
            #1 n++;
         end
         rng("jabber span", 40 * t - 1, 40 * t + 4, n);
         @(posedge clock_i) line_active_i <= 1'b0;
         cyc(2);
         chk("jabber off", 16'h0, {15'h0, jabber_o});
      end
   endtask

   task automatic t_symbols;
      wr(COMPLIANCE_SYMBOL_CONTROL_OFS, 16'h0000);
      cyc(2);
      chk("symbols min", 16'd2, {8'h00, tm1_symbol_count_o});
      wr(COMPLIANCE_SYMBOL_CONTROL_OFS, 16'h03f0);
      cyc(2);
      chk("symbols max", 16'd128, {8'h00, tm1_symbol_count_o});
   endtask

   // Widths are 80 ns doubled per code, rounded up to whole 25 ns cycles
   task automatic t_wake;
      int n;
      for (int s = 0; s < 4; s++) begin
         wr(WAKE_ON_LAN_CONFIG_OFS, 16'h1083 | (16'(s) << 9));
         pulse(s[0] ? 3'b010 : 3'b100, n);
         chk("pulse width", 16'(((80 << s) + 24) / 25), 16'(n));
      end
      pulse(3'b101, n);
      chk("gated", 16'h0, 16'(n));
      wr(WAKE_ON_LAN_CONFIG_OFS, 16'h0083);
      pulse(3'b101, n);
      chk("ungated", 16'h4, 16'(n));
      wr(WAKE_ON_LAN_CONFIG_OFS, 16'h1181);
      pulse(3'b100, n);
      chk("level held", 16'd80, 16'(n));
      wr(WAKE_ON_LAN_CONFIG_OFS, 16'h1981);
      cyc(1);
      chk("level cleared", 16'h0, {15'h0, wake_indication_o});
      rdc("clear reads 0", WAKE_ON_LAN_CONFIG_OFS, 16'h1181);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence; every input set at time zero
   initial begin
      srst_i = 1'b1;
      {wr_i, rd_i, rx_interleave_seen_i, sleep_request_i, line_active_i} = 5'h00;
      addr_i = 16'h0000;
      wdata_i = 16'h0000;
      wake_evt_i = 3'b000;
      do_reset;
      t_reset;
      t_readonly;
      do_reset;
      t_reset;
      t_interleave;
      t_sleep;
      t_jabber;
      t_symbols;
      t_wake;
      report_and_stop;
   end

   // Watchdog well past the roughly 1300 cycles needed
   initial begin
      repeat (20000) @(posedge clock_i);
      n_errors++;
      report_and_stop;
   end
endmodule
